//--- design/transmit_clock_select_rate.sv
// transmit input clock selection, pll rate and output clock generation
// Operation
// - With the select low, every channel input register loads on the reference clock rise.
// - With the select mid, each channel loads data and control on its own input clock rise.
// - With the select high, every channel loads on the channel A input clock rise.
// - With the rate select high, the bit clock is twenty times the reference.
// - With the rate select low, the bit clock is ten times the reference.
// - The character clock output, true and complement, is the bit clock divided by ten.
// - The character clock output comes from the internal character timebase, not the reference.
// - With the reference chosen, receive output clocks follow it at its own rate; the half-rate flag follows rate select.
// - Input clock phase against the reference is tracked while the reset is low, frozen when high.
`timescale 1ns/1ps
module transmit_clock_select_rate (
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic [1:0] tx_input_clock_select_in,
  input wire logic tx_pll_rate_select_in,
  input wire logic rx_output_clock_select_in,
  input wire logic tx_phase_align_reset_in,
  input wire logic reference_clock_in,
  input wire logic rx_recovered_clock_in,
  input wire logic [tx_clock_select_pkg::NUM_CHANNELS-1:0] per_channel_tx_input_clock_in,
  input wire tx_clock_select_pkg::tx_char_s [tx_clock_select_pkg::NUM_CHANNELS-1:0]
    per_channel_tx_char_in,
  output tx_clock_select_pkg::tx_char_s [tx_clock_select_pkg::NUM_CHANNELS-1:0]
    per_channel_tx_char_out,
  output logic [tx_clock_select_pkg::NUM_CHANNELS-1:0] char_loaded_out,
  output logic [tx_clock_select_pkg::NUM_CHANNELS-1:0][tx_clock_select_pkg::CNT_W-1:0]
    input_phase_out,
  output logic [7:0] pll_multiplier_out,
  output logic tx_char_clock_out,
  output logic tx_char_clock_n_out,
  output logic rx_output_clock_a_out,
  output logic rx_output_clock_c_out,
  output logic rx_half_rate_out
);

  localparam int NCH = tx_clock_select_pkg::NUM_CHANNELS;
  localparam int CW = tx_clock_select_pkg::CNT_W;

  // ==========================================================================
  // edge detection on the sampled clock inputs
  logic ref_prev_reg;
  logic [NCH-1:0] chan_prev_reg;
  logic ref_rise;
  logic [NCH-1:0] chan_rise;

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      ref_prev_reg <= 1'h0;
      chan_prev_reg <= '0;
    end else begin
      ref_prev_reg <= reference_clock_in;
      chan_prev_reg <= per_channel_tx_input_clock_in;
    end
  end

  assign ref_rise = reference_clock_in & ~ref_prev_reg;
  assign chan_rise = per_channel_tx_input_clock_in & ~chan_prev_reg;

  // ==========================================================================
  // input register load source per channel
  logic [NCH-1:0] load_strobe;

  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch++) begin : g_chan
      logic [CW-1:0] phase_cnt_reg;
      always_comb begin
        case (tx_input_clock_select_in)
          tx_clock_select_pkg::TX_SEL_MID: load_strobe[ch] = chan_rise[ch];
          tx_clock_select_pkg::TX_SEL_HIGH:
            load_strobe[ch] = chan_rise[tx_clock_select_pkg::CHAN_A];
          default: load_strobe[ch] = ref_rise;
        endcase
      end

      always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
          per_channel_tx_char_out[ch] <= '0;
          char_loaded_out[ch] <= 1'h0;
        end else begin
          char_loaded_out[ch] <= load_strobe[ch];
          if (load_strobe[ch]) begin
            per_channel_tx_char_out[ch] <= per_channel_tx_char_in[ch];
          end
        end
      end

      // cycles from reference rise to this channel's rise; frozen once reset is high
      always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
          phase_cnt_reg <= tx_clock_select_pkg::CNT_ZERO;
          input_phase_out[ch] <= tx_clock_select_pkg::CNT_ZERO;
        end else if (!tx_phase_align_reset_in) begin
          if (ref_rise) begin
            phase_cnt_reg <= tx_clock_select_pkg::CNT_ZERO;
          end else if (phase_cnt_reg != tx_clock_select_pkg::CNT_MAX) begin
            phase_cnt_reg <= phase_cnt_reg + tx_clock_select_pkg::CNT_ONE;
          end
          if (chan_rise[ch]) begin
            input_phase_out[ch] <= phase_cnt_reg;
          end
        end
      end
    end
  endgenerate

  // ==========================================================================
  // reference period measurement, stands in for the pll lock loop
  logic [CW-1:0] ref_cnt_reg;
  logic [CW-1:0] ref_period_reg;

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      ref_cnt_reg <= tx_clock_select_pkg::CNT_ZERO;
      ref_period_reg <= tx_clock_select_pkg::CNT_ZERO;
    end else if (ref_rise) begin
      ref_cnt_reg <= tx_clock_select_pkg::CNT_ONE;
      ref_period_reg <= ref_cnt_reg;
    end else if (ref_cnt_reg != tx_clock_select_pkg::CNT_MAX) begin
      ref_cnt_reg <= ref_cnt_reg + tx_clock_select_pkg::CNT_ONE;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      pll_multiplier_out <= 8'(tx_clock_select_pkg::PLL_MULT_LOW);
    end else if (tx_pll_rate_select_in) begin
      pll_multiplier_out <= 8'(tx_clock_select_pkg::PLL_MULT_HIGH);
    end else begin
      pll_multiplier_out <= 8'(tx_clock_select_pkg::PLL_MULT_LOW);
    end
  end

  // ==========================================================================
  // character clock: bit clock over ten, i.e. reference or twice reference
  logic [CW-1:0] half_period;
  logic [CW-1:0] char_cnt_reg;
  logic char_clk_reg;

  always_comb begin
    if (tx_pll_rate_select_in) begin
      half_period = ref_period_reg >> tx_clock_select_pkg::HALF_SHIFT_HIGH;
    end else begin
      half_period = ref_period_reg >> tx_clock_select_pkg::HALF_SHIFT_LOW;
    end
    if (half_period == tx_clock_select_pkg::CNT_ZERO) begin
      half_period = tx_clock_select_pkg::CNT_ONE;
    end
  end

  // free-running timebase, never re-aligned to the reference edge
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      char_cnt_reg <= tx_clock_select_pkg::CNT_ZERO;
      char_clk_reg <= 1'h0;
    end else if (char_cnt_reg + tx_clock_select_pkg::CNT_ONE >= half_period) begin
      char_cnt_reg <= tx_clock_select_pkg::CNT_ZERO;
      char_clk_reg <= ~char_clk_reg;
    end else begin
      char_cnt_reg <= char_cnt_reg + tx_clock_select_pkg::CNT_ONE;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      tx_char_clock_out <= 1'h0;
    end else begin
      tx_char_clock_out <= char_clk_reg;
    end
  end

  // complement from the same source bit, so the pair never skews apart
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      tx_char_clock_n_out <= 1'h1;
    end else begin
      tx_char_clock_n_out <= ~char_clk_reg;
    end
  end

  // ==========================================================================
  // receive output clocks
  // same frequency and duty as the reference when it is selected, else the recovered clock; rate only renames it
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      rx_output_clock_a_out <= 1'h0;
    end else if (rx_output_clock_select_in == tx_clock_select_pkg::RX_SEL_REFERENCE) begin
      rx_output_clock_a_out <= reference_clock_in;
    end else begin
      rx_output_clock_a_out <= rx_recovered_clock_in;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      rx_output_clock_c_out <= 1'h0;
    end else if (rx_output_clock_select_in == tx_clock_select_pkg::RX_SEL_REFERENCE) begin
      rx_output_clock_c_out <= reference_clock_in;
    end else begin
      rx_output_clock_c_out <= rx_recovered_clock_in;
    end
  end

  // rate label only matters while the reference feeds the receive side
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      rx_half_rate_out <= 1'h0;
    end else if (rx_output_clock_select_in == tx_clock_select_pkg::RX_SEL_REFERENCE) begin
      rx_half_rate_out <= tx_pll_rate_select_in;
    end else begin
      rx_half_rate_out <= 1'h0;
    end
  end

endmodule : transmit_clock_select_rate

//--- design/tx_clock_select_pkg.sv
// shared constants and types for the transmit clock select block
package tx_clock_select_pkg;
  // ==========================================================================
  // sizes
  localparam int NUM_CHANNELS = 4;
  localparam int DATA_W = 8;
  localparam int CTRL_W = 2;
  localparam int CNT_W = 16;
  localparam int CHAN_A = 0;

  // ==========================================================================
  // three-level transmit input clock select, coded on two wires
  localparam logic [1:0] TX_SEL_LOW = 2'h0;
  localparam logic [1:0] TX_SEL_MID = 2'h1;
  localparam logic [1:0] TX_SEL_HIGH = 2'h2;

  // receive output clock source select
  localparam logic RX_SEL_REFERENCE = 1'h0;

  // ==========================================================================
  // pll multiplication and character divider
  localparam int PLL_MULT_HIGH = 20;
  localparam int PLL_MULT_LOW = 10;
  localparam int CHAR_DIVIDE = 10;
  // half period of the character clock: reference period over 2 (x10) or over 4 (x20)
  localparam int HALF_SHIFT_LOW = $clog2((2 * PLL_MULT_LOW) / CHAR_DIVIDE);
  localparam int HALF_SHIFT_HIGH = $clog2((2 * PLL_MULT_HIGH) / CHAR_DIVIDE);

  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;

  // ==========================================================================
  // one parallel transmit character
  typedef struct packed {
    logic [CTRL_W-1:0] control;
    logic [DATA_W-1:0] data;
  } tx_char_s;
endpackage : tx_clock_select_pkg

//--- dv/host_tx_model.sv
// host side model: reference clock and per-channel transmit input clocks
`timescale 1ns/1ps
module host_tx_model #(parameter int HALF = 8) (
  input wire logic clk_sys_in,
  output logic reference_clock_out,
  output logic [3:0] per_channel_tx_input_clock_out
);
  // ==========
  // one counter feeds every clock, so all stay coherent
  int cnt = 0;
  logic [4:0] dly = 5'h00;
  initial begin
    reference_clock_out = 1'b0;
    per_channel_tx_input_clock_out = 4'h0;
  end
  always @(negedge clk_sys_in) begin
    cnt = (cnt + 1) % (2 * HALF);
    reference_clock_out <= (cnt < HALF);
    dly = {dly[3:0], reference_clock_out};
    per_channel_tx_input_clock_out <= dly[4:1];
  end
endmodule : host_tx_model

//--- dv/transmit_clock_select_rate_assertions.sv
// port-level checks of the transmit clock select block
`timescale 1ns/1ps
module transmit_clock_select_rate_assertions (
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic [1:0] tx_input_clock_select_in,
  input wire logic tx_pll_rate_select_in,
  input wire logic rx_output_clock_select_in,
  input wire logic tx_phase_align_reset_in,
  input wire logic reference_clock_in,
  input wire logic rx_recovered_clock_in,
  input wire logic [3:0] per_channel_tx_input_clock_in,
  input wire tx_clock_select_pkg::tx_char_s [3:0] per_channel_tx_char_in,
  input wire tx_clock_select_pkg::tx_char_s [3:0] per_channel_tx_char_out,
  input wire logic [3:0] char_loaded_out,
  input wire logic [3:0][15:0] input_phase_out,
  input wire logic [7:0] pll_multiplier_out,
  input wire logic tx_char_clock_out,
  input wire logic tx_char_clock_n_out,
  input wire logic rx_output_clock_a_out,
  input wire logic rx_output_clock_c_out,
  input wire logic rx_half_rate_out
);
  // ==========
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (srst_in);
  property p_low_load;
    (tx_input_clock_select_in == 2'h0 && $rose(reference_clock_in)) |=>
      char_loaded_out == 4'hF && per_channel_tx_char_out == $past(per_channel_tx_char_in);
  endproperty
  a_low_load: assert property (p_low_load) else $error("low select load wrong");
  property p_mid_load;
    (tx_input_clock_select_in == 2'h1 && $rose(per_channel_tx_input_clock_in[1])) |=>
      char_loaded_out[1] && per_channel_tx_char_out[1] == $past(per_channel_tx_char_in[1]);
  endproperty
  a_mid_load: assert property (p_mid_load) else $error("mid select load wrong");
  property p_high_load;
    (tx_input_clock_select_in == 2'h2 && $rose(per_channel_tx_input_clock_in[0])) |=>
      char_loaded_out == 4'hF;
  endproperty
  a_high_load: assert property (p_high_load) else $error("high select load wrong");
  property p_rate_high;
    tx_pll_rate_select_in |=> pll_multiplier_out == 8'h14;
  endproperty
  a_rate_high: assert property (p_rate_high) else $error("multiplier not 20");
  property p_rate_low;
    !tx_pll_rate_select_in |=> pll_multiplier_out == 8'h0A;
  endproperty
  a_rate_low: assert property (p_rate_low) else $error("multiplier not 10");
  property p_compl;
    tx_char_clock_n_out == !tx_char_clock_out;
  endproperty
  a_compl: assert property (p_compl) else $error("clock pair not complementary");
  property p_rx_ref;
    !rx_output_clock_select_in |=> rx_output_clock_a_out == $past(reference_clock_in) &&
      rx_output_clock_c_out == $past(reference_clock_in) &&
      rx_half_rate_out == $past(tx_pll_rate_select_in);
  endproperty
  a_rx_ref: assert property (p_rx_ref) else $error("rx clocks not from reference");
  property p_rx_other;
    rx_output_clock_select_in |=> !rx_half_rate_out &&
      rx_output_clock_a_out == $past(rx_recovered_clock_in);
  endproperty
  a_rx_other: assert property (p_rx_other) else $error("rate leaks to rx clocks");
  property p_freeze;
    tx_phase_align_reset_in |=> $stable(input_phase_out);
  endproperty
  a_freeze: assert property (p_freeze) else $error("phase moved while frozen");
endmodule : transmit_clock_select_rate_assertions
bind transmit_clock_select_rate transmit_clock_select_rate_assertions
  transmit_clock_select_rate_assertions_inst (.*);

//--- dv/transmit_clock_select_rate_tb_top.sv
// self-checking bench for the transmit clock select block
`timescale 1ns/1ps
module transmit_clock_select_rate_tb_top;
  // ==========
  logic clk_sys_in = 1'b0;
  logic srst_in = 1'b1;
  logic [1:0] tx_input_clock_select_in = 2'h0;
  logic tx_pll_rate_select_in = 1'b0;
  logic rx_output_clock_select_in = 1'b0;
  logic tx_phase_align_reset_in = 1'b0;
  logic rx_recovered_clock_in = 1'b0;
  logic reference_clock_in;
  logic [3:0] per_channel_tx_input_clock_in;
  tx_clock_select_pkg::tx_char_s [3:0] per_channel_tx_char_in = '0;
  tx_clock_select_pkg::tx_char_s [3:0] per_channel_tx_char_out;
  logic [3:0] char_loaded_out;
  logic [3:0][15:0] input_phase_out;
  logic [7:0] pll_multiplier_out;
  logic tx_char_clock_out, tx_char_clock_n_out, rx_output_clock_a_out;
  logic rx_output_clock_c_out, rx_half_rate_out;
  int fails = 0, checks_done = 0, cnt, cyc, last_t;
  logic [31:0] seed = 32'hF24FCEDA, r1;
  logic [9:0] ec[4];
  logic [15:0] ph[4];
  logic [3:0] ldv, pch;
  logic [7:0] mult;
  logic pref, rxa, half, pclk;
  always #2 clk_sys_in = ~clk_sys_in;
  host_tx_model host_tx_model_inst (.clk_sys_in(clk_sys_in),
    .reference_clock_out(reference_clock_in),
    .per_channel_tx_input_clock_out(per_channel_tx_input_clock_in));
  transmit_clock_select_rate transmit_clock_select_rate_inst (.clk_sys_in(clk_sys_in),
    .srst_in(srst_in), .tx_input_clock_select_in(tx_input_clock_select_in),
    .tx_pll_rate_select_in(tx_pll_rate_select_in),
    .rx_output_clock_select_in(rx_output_clock_select_in),
    .tx_phase_align_reset_in(tx_phase_align_reset_in), .reference_clock_in(reference_clock_in),
    .rx_recovered_clock_in(rx_recovered_clock_in),
    .per_channel_tx_input_clock_in(per_channel_tx_input_clock_in),
    .per_channel_tx_char_in(per_channel_tx_char_in),
    .per_channel_tx_char_out(per_channel_tx_char_out), .char_loaded_out(char_loaded_out),
    .input_phase_out(input_phase_out), .pll_multiplier_out(pll_multiplier_out),
    .tx_char_clock_out(tx_char_clock_out), .tx_char_clock_n_out(tx_char_clock_n_out),
    .rx_output_clock_a_out(rx_output_clock_a_out), .rx_output_clock_c_out(rx_output_clock_c_out),
    .rx_half_rate_out(rx_half_rate_out));
  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  task automatic chk(string n, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s exp %0h seen %0h", n, exp, seen);
    end
  endtask : chk
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize
  // ==========
  // reference model, updated on the same edge the design samples
  always @(posedge clk_sys_in) begin : model
    logic c, p;
    if (srst_in) begin
      ldv = 4'h0; pch = 4'h0; pref = 1'b0; cnt = 0; mult = 8'h0A; rxa = 1'b0; half = 1'b0;
      for (int i = 0; i < 4; i++) begin ec[i] = 10'h000; ph[i] = 16'h0000; end
    end else begin
      for (int i = 0; i < 4; i++) begin
        c = tx_input_clock_select_in == 2'h1 ? per_channel_tx_input_clock_in[i] :
            tx_input_clock_select_in == 2'h2 ? per_channel_tx_input_clock_in[0] : reference_clock_in;
        p = tx_input_clock_select_in == 2'h1 ? pch[i] :
            tx_input_clock_select_in == 2'h2 ? pch[0] : pref;
        ldv[i] = c && !p;
        if (ldv[i]) ec[i] = per_channel_tx_char_in[i];
        if (!tx_phase_align_reset_in && per_channel_tx_input_clock_in[i] && !pch[i]) ph[i] = cnt;
      end
      if (!tx_phase_align_reset_in) cnt = (reference_clock_in && !pref) ? 0 : cnt + 1;
      pref = reference_clock_in; pch = per_channel_tx_input_clock_in;
      mult = tx_pll_rate_select_in ? 8'h14 : 8'h0A;
      rxa = rx_output_clock_select_in ? rx_recovered_clock_in : reference_clock_in;
      half = rx_output_clock_select_in ? 1'b0 : tx_pll_rate_select_in;
    end
  end
  always @(negedge clk_sys_in) begin
    if (srst_in) begin cyc = 0; last_t = 0; end
    else begin
      for (int i = 0; i < 4; i++) begin
        chk("char", per_channel_tx_char_out[i], ec[i]);
        chk("phase", input_phase_out[i], ph[i]);
      end
      chk("loaded", char_loaded_out, ldv);
      chk("mult", pll_multiplier_out, mult);
      chk("rx_a", rx_output_clock_a_out, rxa);
      chk("rx_c", rx_output_clock_c_out, rxa);
      chk("half", rx_half_rate_out, half);
      if (tx_char_clock_out !== pclk) begin
        if (last_t > 60) chk("gap", cyc - last_t, tx_pll_rate_select_in ? 4 : 8);
        last_t = cyc;
      end
      cyc++;
    end
    pclk = tx_char_clock_out;
    seed = xs(seed); r1 = seed; seed = xs(seed);
    per_channel_tx_char_in <= {r1[7:0], seed};
    rx_recovered_clock_in <= r1[31];
  end
  initial begin
    // selects only change under reset; the phase align reset goes high after 100 cycles in use
    for (int k = 0; k < 16; k++) begin
      srst_in <= 1'b1;
      tx_input_clock_select_in <= k[1:0];
      tx_pll_rate_select_in <= k[2];
      rx_output_clock_select_in <= k[3];
      tx_phase_align_reset_in <= 1'b0;
      repeat (2) @(negedge clk_sys_in);
      srst_in <= 1'b0;
      repeat (100) @(negedge clk_sys_in);
      tx_phase_align_reset_in <= 1'b1;
      repeat (60) @(negedge clk_sys_in);
      $display("test %0d done", k);
    end
    summarize();
  end
endmodule : transmit_clock_select_rate_tb_top
